// file: core/dwp_consts.vh
`ifndef DWP_CONSTS_VH
`define DWP_CONSTS_VH

// ------------------------------------------------------------
// Clock and timing
// ------------------------------------------------------------
`define DWP_CLK_HZ          200000000
`define DWP_SERIAL_READY_US 10
`define DWP_SERIAL_READY_CYC ((`DWP_SERIAL_READY_US * 200) - 1)
`define DWP_STARTUP_MS      50
`define DWP_STARTUP_CYC     (`DWP_STARTUP_MS * 200000)
`define DWP_PULSE_MIN_MS    1
`define DWP_PULSE_MIN_CYC   (`DWP_PULSE_MIN_MS * 200000)
`define DWP_HOLD_MS         1000
`define DWP_HOLD_CYC        (`DWP_HOLD_MS * 200000)
`define DWP_REPEAT_MS       100
`define DWP_REPEAT_CYC      (`DWP_REPEAT_MS * 200000)
`define DWP_IDLE_MS         1000
`define DWP_IDLE_CYC        (`DWP_IDLE_MS * 200000)

// ------------------------------------------------------------
// Wiper positions
// ------------------------------------------------------------
`define DWP_POS_W           7
`define DWP_POS_HIGH        7'h00
`define DWP_POS_LOW         7'h3F
`define DWP_POS_MUTE        7'h40
`define DWP_TMR_W           28

`endif

// file: core/dwp_sync.v
`timescale 1ns/1ps
`include "dwp_consts.vh"

// Two-flop synchroniser plus debounce for one active-low contact
module dwp_sync #(
  parameter [27:0] DEB_CYC = `DWP_PULSE_MIN_CYC
) (
  input  wire       ref_clk,
  input  wire       rst_n,
  input  wire       key_n,
  output reg        pressed
);
  reg        meta;
  reg        stable;
  reg [27:0] cnt;

  // ----------------------------------------------------------
  // Sync and debounce
  // ----------------------------------------------------------
  // The level must hold for DEB_CYC before it is believed, so
  // bounce and gaps shorter than 1 ms merge into one press
  always @(posedge ref_clk)
  begin
    if (!rst_n)
    begin
      meta    <= 1'b1;
      stable  <= 1'b1;
      cnt     <= 28'h0000000;
      pressed <= 1'b0;
    end
    else
    begin
      meta   <= key_n;
      stable <= meta;
      if (stable == pressed)       // Raw level differs from view
      begin
        if (cnt >= DEB_CYC - 28'h0000001)
        begin
          pressed <= ~stable;
          cnt     <= 28'h0000000;
        end
        else
          cnt <= cnt + 28'h0000001;
      end
      else
        cnt <= 28'h0000000;
    end
  end
endmodule

// file: core/dwp_rate.v
`timescale 1ns/1ps
`include "dwp_consts.vh"

// Turns a debounced press into step pulses, and flags idle time
module dwp_rate #(
  parameter [27:0] HOLD_CYC = `DWP_HOLD_CYC,
  parameter [27:0] REP_CYC  = `DWP_REPEAT_CYC,
  parameter [27:0] IDLE_CYC = `DWP_IDLE_CYC
) (
  input  wire       ref_clk,
  input  wire       rst_n,
  input  wire       enable,
  input  wire       pressed,
  output reg        step,
  output reg        idle
);
  reg        prev;
  reg        rep;
  reg [27:0] cnt;
  reg [27:0] icnt;

  // ----------------------------------------------------------
  // Step generation
  // ----------------------------------------------------------
  // Step on the press, then once every 100 ms after 1 s of hold
  always @(posedge ref_clk)
  begin
    if (!rst_n)
    begin
      prev <= 1'b0;
      rep  <= 1'b0;
      cnt  <= 28'h0000000;
      step <= 1'b0;
    end
    else
    begin
      prev <= pressed & enable;
      step <= 1'b0;
      if (pressed & enable & !prev)
      begin
        step <= 1'b1;
        cnt  <= 28'h0000000;
        rep  <= 1'b0;
      end
      else if (pressed & enable)
      begin
        if (cnt >= (rep ? REP_CYC : HOLD_CYC) - 28'h0000001)
        begin
          step <= 1'b1;
          rep  <= 1'b1;
          cnt  <= 28'h0000000;
        end
        else
          cnt <= cnt + 28'h0000001;
      end
    end
  end

  // ----------------------------------------------------------
  // Inactivity timer
  // ----------------------------------------------------------
  // Idle is a one-cycle pulse, so a long silence flips the
  // single-key direction once instead of on every clock
  always @(posedge ref_clk)
  begin
    if (!rst_n)
    begin
      icnt <= 28'h0000000;
      idle <= 1'b0;
    end
    else if (pressed)
    begin
      icnt <= 28'h0000000;
      idle <= 1'b0;
    end
    else if (icnt < IDLE_CYC)
    begin
      icnt <= icnt + 28'h0000001;
      idle <= (icnt == IDLE_CYC - 28'h0000001);
    end
    else
      idle <= 1'b0;
  end
endmodule

// file: core/dwp_control.v
`timescale 1ns/1ps
`include "dwp_consts.vh"

// Overview of operation
// - Latch mode level once after reset
// - Serial side ready within 10 us
// - Ignore keys for 50 ms after reset
// - Both wipers start at position 63
// - Codes 0..63 attenuate, 64 mutes
// - Independent up key lowers code
// - Independent down key raises code toward 63
// - Key pair 0 to wiper 0, pair 1 wiper 1
// - Single-key mode, up keys steer both ways
// - Volume steps both wipers together
// - Volume stops when either wiper hits end
// - First balance press captures nearer-high wiper
// - Balance 0 lifts wiper 0 until equal
// - Then balance 0 lowers wiper 1
// - Wiper 1 at bottom, balance 0 no-op
// - Both at 63, balance does nothing
// - Press over 1 ms is one step
// - Held over 1 s, step each 100 ms
// - Single-key reverses on idle or end; stereo balance side on idle only
// - Two-key stops at end, no wait
module dwp_control #(
  parameter [27:0] STARTUP_CYC = `DWP_STARTUP_CYC,
  parameter [27:0] DEB_CYC     = `DWP_PULSE_MIN_CYC,
  parameter [27:0] HOLD_CYC    = `DWP_HOLD_CYC,
  parameter [27:0] REP_CYC     = `DWP_REPEAT_CYC,
  parameter [27:0] IDLE_CYC    = `DWP_IDLE_CYC
) (
  input  wire       ref_clk,
  input  wire       rst_n,
  input  wire       mode_sel,
  input  wire       up_key_wiper0_n,
  input  wire       up_key_wiper1_n,
  input  wire       down_key_wiper0_n,
  input  wire       down_key_wiper1_n,
  output reg  [6:0] wiper0_pos,
  output reg  [6:0] wiper1_pos,
  output reg        independent_mode,
  output reg        single_key_mode,
  output reg        keys_active,
  output reg        serial_ready
);
  // Shared pins: in stereo mode they carry volume and balance keys
  // up0 = volume_up_key, up1 = balance_key_0,
  // dn0 = volume_down_key, dn1 = balance_key_1
  wire [3:0] key_n;
  wire [3:0] pressed;
  wire [3:0] step;
  wire [3:0] idle;
  assign key_n = {down_key_wiper1_n, down_key_wiper0_n,
                  up_key_wiper1_n, up_key_wiper0_n};

  // ----------------------------------------------------------
  // Per-contact conditioning
  // ----------------------------------------------------------
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi = gi + 1)
    begin : g_key
      dwp_sync #(
        .DEB_CYC  (DEB_CYC)
      ) u_sync (
        .ref_clk  (ref_clk),
        .rst_n    (rst_n),
        .key_n    (key_n[gi]),
        .pressed  (pressed[gi])
      );
      dwp_rate #(
        .HOLD_CYC (HOLD_CYC),
        .REP_CYC  (REP_CYC),
        .IDLE_CYC (IDLE_CYC)
      ) u_rate (
        .ref_clk  (ref_clk),
        .rst_n    (rst_n),
        .enable   (keys_active),
        .pressed  (pressed[gi]),
        .step     (step[gi]),
        .idle     (idle[gi])
      );
    end
  endgenerate

  // ----------------------------------------------------------
  // Start-up: mode latch, key hold-off, serial ready flag
  // ----------------------------------------------------------
  reg [27:0] boot_cnt;
  reg        latched;
  // Serial flag threshold, held at the counter's width
  localparam [27:0] SER_READY_CYC = `DWP_SERIAL_READY_CYC;
  // Mode and single-key wiring are caught once, on the first
  // edge after reset release; later pin changes are ignored
  always @(posedge ref_clk)
  begin
    if (!rst_n)
    begin
      boot_cnt         <= 28'h0000000;
      latched          <= 1'b0;
      independent_mode <= 1'b1;
      single_key_mode  <= 1'b0;
      keys_active      <= 1'b0;
      serial_ready     <= 1'b0;
    end
    else
    begin
      if (!latched)
      begin
        latched          <= 1'b1;
        independent_mode <= mode_sel;
        single_key_mode  <= down_key_wiper0_n &
                            down_key_wiper1_n;
      end
      if (boot_cnt >= SER_READY_CYC)
        serial_ready <= 1'b1;
      if (boot_cnt >= STARTUP_CYC - 28'h0000001)
        keys_active <= 1'b1;
      // Run on until both flags are up: a short key hold-off
      // must not freeze the serial flag below its threshold
      if (!(keys_active && serial_ready))
        boot_cnt <= boot_cnt + 28'h0000001;
    end
  end

  // ----------------------------------------------------------
  // Wiper move logic
  // ----------------------------------------------------------
  reg [1:0] dir_up;     // Single-key direction per key, 1 = toward 0
  reg       bal_side;   // Single-key balance: 0 = balance-0
  reg       bal_valid;
  reg [6:0] bal_ref;
  reg [6:0] bal_cur;    // Level that balance steps converge on
  reg [6:0] next_w0;
  reg [6:0] next_w1;
  reg [1:0] next_dir;
  reg       next_side;
  reg       b0_ev;
  reg       b1_ev;
  reg       vu_ev;
  reg       vd_ev;

  // Step one wiper inside 0..63; mute code 64 only via serial path
  function [6:0] mv;
    input [6:0] p;
    input       up;
    begin
      if (up)
        mv = (p == `DWP_POS_HIGH) ? p : p - 7'h01;
      else
        mv = (p >= `DWP_POS_LOW) ? p : p + 7'h01;
    end
  endfunction

  always @*
  begin
    next_w0   = wiper0_pos;
    next_w1   = wiper1_pos;
    next_dir  = dir_up;
    next_side = bal_side;
    vu_ev = 1'b0;
    vd_ev = 1'b0;
    b0_ev = 1'b0;
    b1_ev = 1'b0;
    // Balance target: the captured high-side position, or the
    // live one on the first balance press after reset or a volume step
    if (bal_valid)
      bal_cur = bal_ref;
    else if (wiper0_pos < wiper1_pos)
      bal_cur = wiper0_pos;
    else
      bal_cur = wiper1_pos;
    // Idle on a single key flips its direction
    if (single_key_mode)
    begin
      if (idle[0] && !step[0])
        next_dir[0] = ~dir_up[0];
      if (idle[1] && !step[1])
        next_dir[1] = ~dir_up[1];
    end
    if (independent_mode)
    begin
      if (single_key_mode)
      begin
        if (step[0])
        begin
          next_w0 = mv(wiper0_pos, dir_up[0]);
          if (next_w0 == `DWP_POS_HIGH || next_w0 == `DWP_POS_LOW)
            next_dir[0] = ~dir_up[0];
        end
        if (step[1])
        begin
          next_w1 = mv(wiper1_pos, dir_up[1]);
          if (next_w1 == `DWP_POS_HIGH || next_w1 == `DWP_POS_LOW)
            next_dir[1] = ~dir_up[1];
        end
      end
      else
      begin
        // Up key wins a tie; ends simply saturate
        if (step[0])
          next_w0 = mv(wiper0_pos, 1'b1);
        else if (step[2])
          next_w0 = mv(wiper0_pos, 1'b0);
        if (step[1])
          next_w1 = mv(wiper1_pos, 1'b1);
        else if (step[3])
          next_w1 = mv(wiper1_pos, 1'b0);
      end
    end
    else
    begin
      // Decode stereo events from the shared pins
      if (single_key_mode)
      begin
        vu_ev = step[0] & dir_up[0];
        vd_ev = step[0] & ~dir_up[0];
        b0_ev = step[1] & ~bal_side;
        b1_ev = step[1] & bal_side;
        if (idle[1] && !step[1])
          next_side = ~bal_side;
      end
      else
      begin
        vu_ev = step[0] & ~step[2];
        vd_ev = step[2] & ~step[0];
        b0_ev = step[1] & ~step[3];
        b1_ev = step[3] & ~step[1];
      end
      // Volume keeps the offset: blocked if either is at the end
      if (vu_ev)
      begin
        if (wiper0_pos != `DWP_POS_HIGH && wiper1_pos != `DWP_POS_HIGH)
        begin
          next_w0 = wiper0_pos - 7'h01;
          next_w1 = wiper1_pos - 7'h01;
        end
        else if (single_key_mode)
          next_dir[0] = 1'b0;
      end
      else if (vd_ev)
      begin
        if (wiper0_pos < `DWP_POS_LOW && wiper1_pos < `DWP_POS_LOW)
        begin
          next_w0 = wiper0_pos + 7'h01;
          next_w1 = wiper1_pos + 7'h01;
        end
        else if (single_key_mode)
          next_dir[0] = 1'b1;
      end
      // Balance: both at 63 means no move at all
      if (wiper0_pos >= `DWP_POS_LOW && wiper1_pos >= `DWP_POS_LOW)
      begin
        // Nothing moves; volume-up must lift them first
      end
      else if (b0_ev)
      begin
        if (wiper0_pos > bal_cur)
          next_w0 = wiper0_pos - 7'h01;
        else if (wiper1_pos < `DWP_POS_LOW)
          next_w1 = wiper1_pos + 7'h01;
      end
      else if (b1_ev)
      begin
        if (wiper1_pos > bal_cur)
          next_w1 = wiper1_pos - 7'h01;
        else if (wiper0_pos < `DWP_POS_LOW)
          next_w0 = wiper0_pos + 7'h01;
      end
    end
  end

  // ----------------------------------------------------------
  // State registers
  // ----------------------------------------------------------
  always @(posedge ref_clk)
  begin
    if (!rst_n)
    begin
      wiper0_pos <= `DWP_POS_LOW;
      wiper1_pos <= `DWP_POS_LOW;
      dir_up     <= 2'b11;
      bal_side   <= 1'b0;
      bal_valid  <= 1'b0;
      bal_ref    <= `DWP_POS_LOW;
    end
    else
    begin
      wiper0_pos <= next_w0;
      wiper1_pos <= next_w1;
      dir_up     <= next_dir;
      bal_side   <= next_side;
      // Stored high-side position on first balance press; it
      // steers balance steps until the next volume step, even a blocked one
      if ((b0_ev | b1_ev) && !bal_valid)
      begin
        bal_valid <= 1'b1;
        bal_ref   <= (wiper0_pos < wiper1_pos) ? wiper0_pos
                                               : wiper1_pos;
      end
      else if (vu_ev | vd_ev)
        bal_valid <= 1'b0;
    end
  end
endmodule

// file: test/dwp_btn.sv
`timescale 1ns/1ps
// ----------------------------------------
// Pushbutton model, lines idle at pull-up
// ----------------------------------------
module dwp_btn (
  output reg [3:0] key_n,
  input  wire      ref_clk
);
  initial key_n = 4'hF;
  // Strap one line low or let it return high
  task hold(input int i, input logic v);
    @(negedge ref_clk) key_n[i] = v;
  endtask
  // A closure is held for the length given, released to the pull-up
  task press(input int i, input int len);
    @(negedge ref_clk) key_n[i] = 1'b0;
    repeat (len) @(negedge ref_clk);
    key_n[i] = 1'b1;
  endtask
endmodule

// file: test/dwp_control_properties.sv
`timescale 1ns/1ps
// ----------------------------------------
// Port checker
// ----------------------------------------
module dwp_control_properties #(
  parameter int STARTUP_CYC = 100
) (
  input wire       ref_clk,
  input wire       rst_n,
  input wire       mode_sel,
  input wire       up_key_wiper0_n,
  input wire       up_key_wiper1_n,
  input wire       down_key_wiper0_n,
  input wire       down_key_wiper1_n,
  input wire [6:0] wiper0_pos,
  input wire [6:0] wiper1_pos,
  input wire       independent_mode,
  input wire       single_key_mode,
  input wire       keys_active,
  input wire       serial_ready
);
  localparam int SER_CYC = 2000;
  logic [15:0] cnt;
  // Cycles since reset release; saturates so long runs stay quiet
  always @(posedge ref_clk)
    if (!rst_n) cnt <= 16'h0000;
    else if (cnt != 16'hFFFF) cnt <= cnt + 16'h0001;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  // Two-key independent press, long enough to pass debounce
  sequence ready0;
    keys_active && independent_mode && !single_key_mode &&
      wiper0_pos != 7'h00 && down_key_wiper0_n;
  endsequence
  sequence press0;
    $fell(up_key_wiper0_n) ##1 !up_key_wiper0_n [*8];
  endsequence
  rst_vals_a: assert property (
    $rose(rst_n) |-> wiper0_pos == 7'h3F && wiper1_pos == 7'h3F)
    else $error("wipers not at 63 after reset");
  keys_early_a: assert property (
    cnt + 2 < STARTUP_CYC |-> !keys_active)
    else $error("keys active too early");
  keys_late_a: assert property (
    cnt > STARTUP_CYC + 2 |-> keys_active)
    else $error("keys not active after start-up");
  keys_block_a: assert property (
    !keys_active |=> $stable(wiper0_pos) && $stable(wiper1_pos))
    else $error("wiper moved before keys active");
  serial_late_a: assert property (
    cnt > SER_CYC + 2 |-> serial_ready)
    else $error("serial side late");
  pos_range_a: assert property (
    wiper0_pos <= 7'h40 && wiper1_pos <= 7'h40)
    else $error("position out of range");
  one_step_a: assert property (
    wiper0_pos != $past(wiper0_pos) |-> wiper0_pos ==
      $past(wiper0_pos) + 7'h01 || wiper0_pos == $past(wiper0_pos) - 7'h01)
    else $error("wiper 0 moved more than one step");
  vol_offset_a: assert property (
    !independent_mode && wiper0_pos != $past(wiper0_pos) &&
      wiper1_pos != $past(wiper1_pos) |-> wiper0_pos - wiper1_pos ==
      $past(wiper0_pos) - $past(wiper1_pos))
    else $error("volume changed the offset");
  mode_hold_a: assert property (
    $past(rst_n, 2) && $past(rst_n) |->
      $stable(independent_mode) && $stable(single_key_mode))
    else $error("latched mode changed");
  // Fixed window assumes a debounce of 8 cycles
  up_press_a: assert property (
    ready0 ##0 press0 ##1 !up_key_wiper0_n [*6] |->
      wiper0_pos == $past(wiper0_pos, 14) - 7'h01 &&
      wiper1_pos == $past(wiper1_pos, 14))
    else $error("up press did not step wiper 0 alone");
endmodule
bind dwp_control dwp_control_properties #(.STARTUP_CYC(STARTUP_CYC)) chk (
  .ref_clk(ref_clk), .rst_n(rst_n), .mode_sel(mode_sel),
  .up_key_wiper0_n(up_key_wiper0_n), .up_key_wiper1_n(up_key_wiper1_n),
  .down_key_wiper0_n(down_key_wiper0_n),
  .down_key_wiper1_n(down_key_wiper1_n),
  .wiper0_pos(wiper0_pos), .wiper1_pos(wiper1_pos),
  .independent_mode(independent_mode), .single_key_mode(single_key_mode),
  .keys_active(keys_active), .serial_ready(serial_ready));

// file: test/tb_top.sv
`timescale 1ns/1ps
// ----------------------------------------
// Bench
// ----------------------------------------
module tb_top;
  localparam int ST = 100, DB = 8, HC = 200, RC = 20, IC = 200;
  logic        ref_clk, rst_n, mode_sel, free_run;
  logic [13:0] prev;
  logic [13:0] exp_q[$];
  wire  [3:0]  k;
  wire  [6:0]  w0, w1;
  wire         im, sk, ka, sr;
  int          n_fail, checked, cyc, nchg, gap, last;
  dwp_control #(.STARTUP_CYC(ST), .DEB_CYC(DB), .HOLD_CYC(HC),
    .REP_CYC(RC), .IDLE_CYC(IC)) uut (
    .ref_clk(ref_clk), .rst_n(rst_n), .mode_sel(mode_sel),
    .up_key_wiper0_n(k[0]), .up_key_wiper1_n(k[1]),
    .down_key_wiper0_n(k[2]), .down_key_wiper1_n(k[3]),
    .wiper0_pos(w0), .wiper1_pos(w1), .independent_mode(im),
    .single_key_mode(sk), .keys_active(ka), .serial_ready(sr));
  dwp_btn btn (.key_n(k), .ref_clk(ref_clk));
  // 200 MHz clock
  initial
  begin
    ref_clk = 1'b0;
    forever #2.5 ref_clk = ~ref_clk;
  end
  task check(input string nm, input logic [31:0] seen, exp);
    checked++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("wrong value %s expected %0h seen %0h", nm, exp, seen);
    end
  endtask
  task test_done;
    if (n_fail == 0 && checked > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  // Outside free_run and reset, every wiper move takes the oldest note; a move with none is an error
  always @(negedge ref_clk)
  begin
    cyc++;
    if (rst_n && {w0, w1} !== prev)
    begin
      gap = cyc - last;
      last = cyc;
      nchg++;
      if (!free_run && exp_q.size() == 0) check("spare move", 1, 0);
      else if (!free_run) check("wipers", {w0, w1}, exp_q.pop_front());
    end
    prev = {w0, w1};
  end
  // Reset with a mode level and an optional strap; a press during start-up
  task reset(input logic m, input int s);
    @(negedge ref_clk);
    rst_n = 1'b0;
    mode_sel = m;
    if (s >= 0) btn.hold(s, 1'b0);
    repeat (20) @(negedge ref_clk);
    rst_n = 1'b1;
    repeat (2) @(negedge ref_clk);
    if (s >= 0) btn.hold(s, 1'b1);
    check("indep", im, m);
    check("single", sk, s < 0);
    check("w0 start", w0, 7'h3F);
    check("w1 start", w1, 7'h3F);
    btn.press(0, 30);
    repeat (ST) @(negedge ref_clk);
    check("active", ka, 1);
  endtask
  // One random-length press, then a random gap below the idle time
  task tap(input int i, input logic [6:0] e0, e1);
    if ({e0, e1} !== {w0, w1}) exp_q.push_back({e0, e1});
    btn.press(i, DB + 8 + $urandom % 20);
    repeat (DB + 6 + $urandom % 20) @(negedge ref_clk);
  endtask
  // Hang guard, well past the expected run length
  initial
  begin
    repeat (20000) @(posedge ref_clk);
    n_fail++;
    test_done;
  end
  initial
  begin
    rst_n = 1'b0;
    mode_sel = 1'b1;
    free_run = 1'b0;
    prev = 14'h1FBF;
    void'($urandom(74));
    reset(1, 2);
    tap(0, 62, 63);
    tap(2, 63, 63);
    tap(2, 63, 63);
    tap(3, 63, 63);
    btn.press(1, 3);
    repeat (20) @(negedge ref_clk);
    tap(1, 63, 62);
    // Held key: moves are counted, not predicted one by one
    free_run = 1'b1;
    nchg = 0;
    btn.press(1, HC + 3 * RC + DB + 10);
    repeat (20) @(negedge ref_clk);
    free_run = 1'b0;
    check("repeat gap", gap, RC);
    check("repeats", nchg, 5);
    check("hold pos", w1, 62 - nchg);
    repeat (2000) @(negedge ref_clk);
    check("serial", sr, 1);
    reset(0, 2);
    tap(0, 62, 62);
    mode_sel = 1'b1;
    tap(1, 62, 63);
    tap(1, 62, 63);
    tap(3, 62, 62);
    tap(3, 63, 62);
    tap(2, 63, 62);
    tap(0, 62, 61);
    tap(1, 61, 61);
    reset(0, 3);
    tap(1, 63, 63);
    tap(3, 63, 63);
    tap(0, 62, 62);
    reset(1, -1);
    tap(0, 62, 63);
    tap(0, 61, 63);
    repeat (IC + 20) @(negedge ref_clk);
    tap(0, 62, 63);
    tap(0, 63, 63);
    tap(0, 62, 63);
    // Stereo single key: silence after start-up has flipped both
    reset(0, -1);
    repeat (IC + 20) @(negedge ref_clk);
    tap(0, 63, 63);
    tap(0, 62, 62);
    tap(0, 61, 61);
    tap(1, 62, 61);
    repeat (IC + 20) @(negedge ref_clk);
    tap(1, 61, 61);
    tap(1, 61, 62);
    check("pending", exp_q.size(), 0);
    test_done;
  end
endmodule
